// *** inc/fsf_pkg.sv ***
// Constants for the fault status flag bank: register indices, addresses,
// field positions and values after reset.
// Assumes a 32-bit APB slave with one aligned word per register.
`default_nettype none

package fsf_pkg;
  // Bus and register widths, flag and event counts
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 16;
  localparam int unsigned N_FLAGS = 4;
  localparam int unsigned N_EVENTS = 8;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_INTEG = 10'h005;
  localparam logic [9:0] IDX_OCC = 10'h006;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h00a;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h00b;
  localparam logic [ADDR_W-1:0] ADDR_INTEG = {IDX_INTEG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_OCC = {IDX_OCC, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

  // Integrity check status field positions
  localparam int unsigned SEC1_BIT = 15;
  localparam int unsigned SEC2_BIT = 14;
  localparam int unsigned SEC3_BIT = 13;
  localparam int unsigned MEM_BIT = 11;
  localparam int unsigned BANK_BIT = 10;

  // Overcurrent flag status field positions
  localparam int unsigned A_HIGH_BIT = 3;
  localparam int unsigned A_LOW_BIT = 2;
  localparam int unsigned B_HIGH_BIT = 1;
  localparam int unsigned B_LOW_BIT = 0;

  // Values after reset
  localparam logic [REG_W-1:0] INTEG_RST = 16'hec00;
  localparam logic [REG_W-1:0] OCC_RST = 16'h000f;
  localparam logic [N_FLAGS-1:0] FLAGS_RST = 4'hf;
  localparam logic [N_EVENTS-1:0] IRQ_STAT_RST = 8'h00;
  localparam logic [N_EVENTS-1:0] IRQ_MASK_RST = 8'h00;
endpackage : fsf_pkg

`default_nettype wire

// *** logic/fsf_flag_bank.sv ***
// Bank of active-low sticky fault flags, cleared by writing one.
// Assumes detect and clear pulses are synchronous to the clock.
`default_nettype none
`timescale 1ns/10ps

module fsf_flag_bank
  import fsf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Events and software clears
  input wire logic [N_FLAGS-1:0] detect_i,
  input wire logic [N_FLAGS-1:0] clear_i,
  // Flags, zero means fault seen
  output logic [N_FLAGS-1:0] flag_r
);

  // One flop per flag; detection beats a clear in the same cycle
  for (genvar i = 0; i < N_FLAGS; i++) begin : g_flag
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        flag_r[i] <= FLAGS_RST[i]; // [R4]
      end else if (detect_i[i]) begin
        flag_r[i] <= 1'b0; // [R4] [R18]
      end else if (clear_i[i]) begin
        flag_r[i] <= 1'b1; // [R5]
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_flag_hold: assert property ((~$past(detect_i) & ~$past(clear_i) & (flag_r ^ $past(flag_r))) == '0) // [R17]
    else $error("flag changed with no detect and no clear");
  a_flag_set_wins: assert property ((flag_r & $past(detect_i)) == '0) // [R18]
    else $error("flag not zero after detection");

endmodule : fsf_flag_bank

`default_nettype wire

// *** logic/fsf_irq_ctrl.sv ***
// Sticky interrupt status with mask and one level interrupt output.
// Assumes the bus side hands in the bits that a status read returned.
`default_nettype none
`timescale 1ns/10ps

module fsf_irq_ctrl
  import fsf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Event pulses
  input wire logic [N_EVENTS-1:0] event_i,
  // Software side
  input wire logic mask_wr_i,
  input wire logic [N_EVENTS-1:0] mask_wdata_i,
  input wire logic [N_EVENTS-1:0] rd_clr_i,
  output logic [N_EVENTS-1:0] status_r,
  output logic [N_EVENTS-1:0] mask_r,
  output logic irq
);

  // Only bits that were returned by the read are cleared, so nothing is lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= IRQ_STAT_RST;
    end else begin
      status_r <= (status_r & ~rd_clr_i) | event_i;
    end
  end

  // Mask register, one enables the bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_r <= IRQ_MASK_RST;
    end else if (mask_wr_i) begin
      mask_r <= mask_wdata_i;
    end
  end

  assign irq = |(status_r & mask_r);

endmodule : fsf_irq_ctrl

`default_nettype wire

// *** logic/fsf_status_regs.sv ***
// Fault status flag bank: integrity check status and overcurrent flag status
// registers behind an APB slave, plus an interrupt status and mask pair.
// Assumes detection inputs are one-cycle pulses synchronous to pclk and that
// the fuse bank level is stable around the release of reset.
//
// Overview of operation
// R1: Section one check failure (40h to 59h) drives integrity bit 15 low.
// R2: Section two check failure (80h to A3h) drives integrity bit 14 low.
// R3: Section three check failure (C0h to E3h) drives integrity bit 13 low.
// R4: Fault flags are active low: zero is fault seen, one no fault.
// R5: Writing one to a flag bit returns it to one; host acknowledges this way.
// R6: Internal memory map check mismatch drives integrity bit 11 low.
// R7: Host resets the device if the memory flag keeps returning to zero.
// R8: Bit 10 is read-only, shows fuse bank chosen at reset, one is primary.
// R9: Fuse bank indication never feeds the logic fault summary.
// R10: Host resets the device when the backup fuse bank was loaded.
// R11: Integrity register at 05h, resets EC00h; bits 12 and 9..0 read zero.
// R12: Overcurrent register at 06h, resets 000Fh; flags in bits 3..0, rest zero.
// R13: Converter A high trip drives overcurrent bit 3 low.
// R14: Converter A low trip drives overcurrent bit 2 low.
// R15: Converter B high trip drives overcurrent bit 1 low.
// R16: Converter B low trip drives overcurrent bit 0 low.
// R17: A flag stays zero until written with one; writing zero changes nothing.
// R18: A fault present during the clear drives the flag back to zero.
//
// The APB slave port was left to the implementer.
`default_nettype none
`timescale 1ns/10ps

module fsf_status_regs
  import fsf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Integrity check failure pulses
  input wire logic sec1_check_fail,
  input wire logic sec2_check_fail,
  input wire logic sec3_check_fail,
  input wire logic mem_check_fail,
  // Fuse bank selection level, one for the primary bank
  input wire logic fuse_bank_primary,
  // Overcurrent comparator trip pulses, debounce already applied
  input wire logic converter_a_high_trip_det,
  input wire logic converter_a_low_trip_det,
  input wire logic converter_b_high_trip_det,
  input wire logic converter_b_low_trip_det,
  // Summary and interrupt
  output logic logic_fault_summary,
  output logic irq
);

  logic [N_FLAGS-1:0] integ_det;
  logic [N_FLAGS-1:0] integ_clr;
  logic [N_FLAGS-1:0] integ_flag;
  logic [N_FLAGS-1:0] occ_det;
  logic [N_FLAGS-1:0] occ_clr;
  logic [N_FLAGS-1:0] occ_flag;
  logic [N_EVENTS-1:0] irq_status;
  logic [N_EVENTS-1:0] irq_mask;
  logic [N_EVENTS-1:0] irq_rd_clr;
  logic [REG_W-1:0] integ_word;
  logic [REG_W-1:0] occ_word;
  logic [DATA_W-1:0] rd_nxt;
  logic [DATA_W-1:0] prdata_r;
  logic bank_r;
  logic captured_r;
  logic setup_ph;
  logic access_ph;
  logic addr_hit;
  logic wr_integ;
  logic wr_occ;
  logic wr_mask;
  logic rd_irq;

  // Bus phases; the slave never inserts wait states
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign addr_hit = (paddr == ADDR_INTEG) | (paddr == ADDR_OCC) |
                    (paddr == ADDR_IRQ_STAT) | (paddr == ADDR_IRQ_MASK);
  assign pready = access_ph;
  assign pslverr = access_ph & ~addr_hit; // Unmapped addresses answer with an error

  // Write strobes; flags live in the low half-word, so lanes 0 and 1 matter
  assign wr_integ = access_ph & pwrite & (paddr == ADDR_INTEG) & pstrb[1];
  assign wr_occ = access_ph & pwrite & (paddr == ADDR_OCC) & pstrb[0];
  assign wr_mask = access_ph & pwrite & (paddr == ADDR_IRQ_MASK) & pstrb[0];
  assign rd_irq = access_ph & ~pwrite & (paddr == ADDR_IRQ_STAT);

  // Integrity detections, flag index 3 down to 0
  assign integ_det = {sec1_check_fail, // [R1]
                      sec2_check_fail, // [R2]
                      sec3_check_fail, // [R3]
                      mem_check_fail}; // [R6]

  // Overcurrent detections follow the register bit order directly
  assign occ_det[A_HIGH_BIT] = converter_a_high_trip_det; // [R13]
  assign occ_det[A_LOW_BIT] = converter_a_low_trip_det; // [R14]
  assign occ_det[B_HIGH_BIT] = converter_b_high_trip_det; // [R15]
  assign occ_det[B_LOW_BIT] = converter_b_low_trip_det; // [R16]

  // Write one clears; a zero in the data leaves the flag alone
  assign integ_clr = wr_integ ? {pwdata[SEC1_BIT], pwdata[SEC2_BIT], pwdata[SEC3_BIT], pwdata[MEM_BIT]}
                              : '0; // [R5] [R17]
  assign occ_clr = wr_occ ? pwdata[N_FLAGS-1:0] : '0; // [R5] [R17]

  // Integrity flags
  fsf_flag_bank u_integ_flags (
    .clk(pclk),
    .rstn(presetn),
    .detect_i(integ_det),
    .clear_i(integ_clr),
    .flag_r(integ_flag)
  );

  // Overcurrent flags
  fsf_flag_bank u_occ_flags (
    .clk(pclk),
    .rstn(presetn),
    .detect_i(occ_det),
    .clear_i(occ_clr),
    .flag_r(occ_flag)
  );

  // Fuse bank is caught once, on the first edge after reset release, and then
  // frozen; software has no way to write it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_r <= INTEG_RST[BANK_BIT];
      captured_r <= 1'b0;
    end else if (!captured_r) begin
      bank_r <= fuse_bank_primary; // [R8]
      captured_r <= 1'b1;
    end
  end

  // Register images; reserved bits stay zero
  always_comb begin
    integ_word = '0; // [R11]
    integ_word[SEC1_BIT] = integ_flag[3];
    integ_word[SEC2_BIT] = integ_flag[2];
    integ_word[SEC3_BIT] = integ_flag[1];
    integ_word[MEM_BIT] = integ_flag[0];
    integ_word[BANK_BIT] = bank_r; // [R8]
    occ_word = '0; // [R12]
    occ_word[N_FLAGS-1:0] = occ_flag;
  end

  // Summary is low on any integrity fault; the bank bit is left out on purpose
  // Flags are active low, so the AND of them is high only while all are clean
  assign logic_fault_summary = &integ_flag; // [R9]

  // Read mux, looked up during the setup phase
  always_comb begin
    rd_nxt = '0;
    if (!pwrite) begin
      unique case (paddr)
        ADDR_INTEG: rd_nxt = {16'h0000, integ_word}; // [R11]
        ADDR_OCC: rd_nxt = {16'h0000, occ_word}; // [R12]
        ADDR_IRQ_STAT: rd_nxt = {24'h000000, irq_status};
        ADDR_IRQ_MASK: rd_nxt = {24'h000000, irq_mask};
        default: rd_nxt = '0;
      endcase
    end
  end

  // Read data registered at setup so it is a flop output during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup_ph) begin
      prdata_r <= rd_nxt;
    end
  end

  assign prdata = prdata_r;

  // Clearing only the bits returned by the read keeps a late event sticky
  assign irq_rd_clr = rd_irq ? prdata_r[N_EVENTS-1:0] : '0;

  // Interrupt status: integrity events low nibble, overcurrent high nibble
  fsf_irq_ctrl u_irq (
    .clk(pclk),
    .rstn(presetn),
    .event_i({occ_det, integ_det}),
    .mask_wr_i(wr_mask),
    .mask_wdata_i(pwdata[N_EVENTS-1:0]),
    .rd_clr_i(irq_rd_clr),
    .status_r(irq_status),
    .mask_r(irq_mask),
    .irq(irq)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus steps used by the checks below
  sequence s_integ_read;
    setup_ph && !pwrite && (paddr == ADDR_INTEG) ##1 access_ph;
  endsequence

  sequence s_occ_read;
    setup_ph && !pwrite && (paddr == ADDR_OCC) ##1 access_ph;
  endsequence

  sequence s_sec1_clear;
    wr_integ && pwdata[SEC1_BIT] && !sec1_check_fail;
  endsequence

  sequence s_stat_read;
    setup_ph && !pwrite && (paddr == ADDR_IRQ_STAT) ##1 access_ph;
  endsequence

  a_sec1_fault_low: assert property (sec1_check_fail |=> !integ_word[SEC1_BIT] && !logic_fault_summary) // [R1]
    else $error("section one flag not low after failure");

  a_sec2_fault_low: assert property (sec2_check_fail |=> !integ_word[SEC2_BIT]) // [R2]
    else $error("section two flag not low after failure");

  a_sec3_fault_low: assert property (sec3_check_fail |=> !integ_word[SEC3_BIT]) // [R3]
    else $error("section three flag not low after failure");

  a_mem_fault_low: assert property (mem_check_fail |=> !integ_word[MEM_BIT]) // [R6]
    else $error("memory map flag not low after mismatch");

  a_fault_sticks: assert property (sec1_check_fail ##1 (!wr_integ || !pwdata[SEC1_BIT]) [*3]
                                   |-> !integ_word[SEC1_BIT]) // [R4]
    else $error("section one flag released without a clear");

  a_write_one_clears: assert property (s_sec1_clear |=> integ_word[SEC1_BIT]) // [R5]
    else $error("write one did not restore section one flag");

  a_redetect_wins: assert property (wr_occ && pwdata[A_HIGH_BIT] && converter_a_high_trip_det
                                    |=> !occ_word[A_HIGH_BIT]) // [R18]
    else $error("clear beat a detection in the same cycle");

  a_bank_frozen: assert property (captured_r && $past(captured_r) |-> $stable(bank_r)) // [R8]
    else $error("fuse bank indication changed after capture");

  a_bank_capture: assert property (!captured_r |=> bank_r == $past(fuse_bank_primary)) // [R8]
    else $error("fuse bank not caught after reset release");

  // Checked against the register image, so a bank bit leaking in would show
  a_summary_no_bank: assert property (logic_fault_summary == (integ_word[SEC1_BIT] && integ_word[SEC2_BIT]
                                      && integ_word[SEC3_BIT] && integ_word[MEM_BIT])) // [R9]
    else $error("summary does not follow integrity flags alone");

  a_integ_reserved: assert property (s_integ_read |-> (prdata[12] == 1'b0) && (prdata[9:0] == 10'h000)
                                     && (prdata[31:16] == 16'h0000)) // [R11]
    else $error("reserved integrity bits not zero");

  a_occ_reserved: assert property (s_occ_read |-> prdata[31:4] == 28'h0000000) // [R12]
    else $error("reserved overcurrent bits not zero");

  a_a_high_trip: assert property (converter_a_high_trip_det |=> !occ_word[A_HIGH_BIT]) // [R13]
    else $error("converter a high flag not low");

  a_a_low_trip: assert property (converter_a_low_trip_det |=> !occ_word[A_LOW_BIT]) // [R14]
    else $error("converter a low flag not low");

  a_b_high_trip: assert property (converter_b_high_trip_det |=> !occ_word[B_HIGH_BIT]) // [R15]
    else $error("converter b high flag not low");

  a_b_low_trip: assert property (converter_b_low_trip_det |=> !occ_word[B_LOW_BIT]) // [R16]
    else $error("converter b low flag not low");

  a_zero_write_keeps: assert property (wr_occ && !pwdata[B_LOW_BIT] && !occ_word[B_LOW_BIT]
                                       |=> !occ_word[B_LOW_BIT]) // [R17]
    else $error("writing zero changed an overcurrent flag");

  // A masked-in event must raise the line in the cycle after the pulse
  a_irq_event: assert property (sec2_check_fail |=> irq_status[2] && (irq || !irq_mask[2]))
    else $error("event did not reach interrupt status");

  a_stat_read_clr: assert property (s_stat_read ##0 (prdata[0] && !mem_check_fail) |=> !irq_status[0])
    else $error("status read did not clear returned bit");

  a_unmapped_err: assert property (access_ph && !addr_hit |-> pslverr && pready)
    else $error("unmapped access not answered with error");

  // Transfer steps for the bus answer checks
  sequence s_bus_access;
    setup_ph ##1 access_ph;
  endsequence

  sequence s_write_access;
    setup_ph && pwrite ##1 access_ph;
  endsequence

  sequence s_unmapped_read;
    setup_ph && !pwrite && !addr_hit ##1 access_ph;
  endsequence

  // The host never waits: the first access cycle is answered
  a_ready_at_access: assert property (s_bus_access |-> pready)
    else $error("access cycle not answered at once");

  a_read_data_held: assert property (s_bus_access |-> prdata == $past(rd_nxt))
    else $error("read data changed between setup and access");

  a_write_reads_zero: assert property (s_write_access |-> prdata == '0)
    else $error("write returned nonzero read data");

  a_unmapped_rd_zero: assert property (s_unmapped_read |-> prdata == '0 && pslverr)
    else $error("unmapped read returned data");

  a_idle_quiet: assert property (!psel |-> !pready && !pslverr)
    else $error("answer seen with no transfer");

  // Flag clears and zero writes on the other bits
  a_sec2_zero_keeps: assert property (wr_integ && !pwdata[SEC2_BIT] && !integ_word[SEC2_BIT]
                                      |=> !integ_word[SEC2_BIT]) // [R17]
    else $error("writing zero changed section two flag");

  a_mem_one_clears: assert property (wr_integ && pwdata[MEM_BIT] && !mem_check_fail
                                     |=> integ_word[MEM_BIT]) // [R5]
    else $error("write one did not restore memory map flag");

  a_occ_one_clears: assert property (wr_occ && pwdata[B_HIGH_BIT] && !converter_b_high_trip_det
                                     |=> occ_word[B_HIGH_BIT]) // [R5]
    else $error("write one did not restore converter b high flag");

  // A bus write must never reach the fuse bank indication
  a_bank_write_ignored: assert property (wr_integ && pwdata[BANK_BIT] && captured_r
                                         |=> $stable(bank_r)) // [R8]
    else $error("fuse bank indication changed by a write");

  // Interrupt status is cleared by reads only, and the mask gates the line
  a_stat_sticky: assert property (irq_status[3] && !rd_irq |=> irq_status[3])
    else $error("interrupt status bit lost without a read");

  a_stat_write_ignored: assert property (access_ph && pwrite && (paddr == ADDR_IRQ_STAT)
                                         && (occ_det == '0) && (integ_det == '0) |=> $stable(irq_status))
    else $error("write changed interrupt status");

  a_mask_write: assert property (wr_mask |=> irq_mask == $past(pwdata[N_EVENTS-1:0]))
    else $error("mask write did not land");

  a_irq_mask_off: assert property (irq_mask == '0 |-> !irq)
    else $error("interrupt raised with every source masked");

endmodule : fsf_status_regs

`default_nettype wire

// *** dv/fsf_host_model.sv ***
// Host processor model: an APB master that reads and clears fault flags.
// Assumes a zero or more wait state slave clocked by pclk.
`default_nettype none
`timescale 1ns/10ps

module fsf_host_model
  import fsf_pkg::*;
(
  // Clock
  input wire logic pclk,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [DATA_W-1:0] pwdata,
  output logic [3:0] pstrb,
  // APB answer
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
  end

  // One transfer; a write of ones is how the host acknowledges a fault
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until pready is seen high at an edge
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : fsf_host_model

`default_nettype wire

// *** dv/test_fsf_status_regs.sv ***
// Self-checking bench for the fault status flag bank.
// Assumes the host model in dv/ and the design package are compiled first.
`default_nettype none
`timescale 1ns/10ps

module test_fsf_status_regs;
  import fsf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic fuse = 1'b1;
  logic [7:0] det = 8'h00;
  logic psel, penable, pwrite, pready, pslverr, summary, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [3:0] pstrb;
  int error_cnt = 0;
  int check_count = 0;
  // Detector order: sec1, sec2, sec3, mem, A high, A low, B high, B low
  int pos[8] = '{SEC1_BIT, SEC2_BIT, SEC3_BIT, MEM_BIT, A_HIGH_BIT, A_LOW_BIT, B_HIGH_BIT, B_LOW_BIT};
  int ib[8] = '{3, 2, 1, 0, 7, 6, 5, 4};

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  fsf_status_regs fsf_status_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sec1_check_fail(det[0]), .sec2_check_fail(det[1]),
    .sec3_check_fail(det[2]), .mem_check_fail(det[3]), .fuse_bank_primary(fuse),
    .converter_a_high_trip_det(det[4]), .converter_a_low_trip_det(det[5]),
    .converter_b_high_trip_det(det[6]), .converter_b_low_trip_det(det[7]),
    .logic_fault_summary(summary), .irq(irq));

  fsf_host_model fsf_host_model_inst (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Read and compare data and error response
  task automatic rdc(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic ee);
    logic [DATA_W-1:0] q;
    logic er;
    fsf_host_model_inst.xfer(1'b0, a, '0, q, er);
    chk(n, e, q);
    chk({n, " slverr"}, {31'h0, ee}, {31'h0, er});
  endtask : rdc

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [DATA_W-1:0] q;
    logic er;
    fsf_host_model_inst.xfer(1'b1, a, d, q, er);
    chk("write slverr", 32'h0, {31'h0, er});
  endtask : wr

  // Reset held 16 cycles with a chosen fuse bank level
  task automatic rst(input logic f);
    @(posedge pclk);
    presetn <= 1'b0;
    fuse <= f;
    det <= 8'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst

  task automatic pulse(input int i);
    @(posedge pclk);
    det[i] <= 1'b1;
    @(posedge pclk);
    det[i] <= 1'b0;
  endtask : pulse

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Watchdog well beyond the expected run of about 300 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end

  initial begin
    logic [ADDR_W-1:0] a;
    logic [31:0] rv;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc("integrity reset", ADDR_INTEG, 32'h0000ec00, 1'b0);
    rdc("overcurrent reset", ADDR_OCC, 32'h0000000f, 1'b0);
    rdc("irq mask reset", ADDR_IRQ_MASK, 32'h0, 1'b0);
    rdc("unmapped", 12'h100, 32'h0, 1'b1);
    $display("test reset values done");
    wr(ADDR_IRQ_MASK, 32'hff);
    rdc("irq mask", ADDR_IRQ_MASK, 32'hff, 1'b0);
    // Each detector: set, sticky against zero write, interrupt, clear by one
    for (int i = 0; i < 8; i++) begin
      a = (i < 4) ? ADDR_INTEG : ADDR_OCC;
      rv = (i < 4) ? 32'h0000ec00 : 32'h0000000f;
      pulse(i);
      @(negedge pclk);
      chk("irq set", 32'h1, {31'h0, irq});
      chk("summary", (i < 4) ? 32'h0 : 32'h1, {31'h0, summary});
      rdc("flag set", a, rv & ~(32'h1 << pos[i]), 1'b0);
      wr(a, 32'h0);
      rdc("zero write", a, rv & ~(32'h1 << pos[i]), 1'b0);
      rdc("irq status", ADDR_IRQ_STAT, 32'h1 << ib[i], 1'b0);
      @(negedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(a, 32'h1 << pos[i]);
      rdc("flag cleared", a, rv, 1'b0);
    end
    $display("test detectors done");
    wr(ADDR_IRQ_MASK, 32'h0);
    pulse(4);
    @(negedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdc("masked status", ADDR_IRQ_STAT, 32'h80, 1'b0);
    rdc("status read clear", ADDR_IRQ_STAT, 32'h0, 1'b0);
    wr(ADDR_IRQ_STAT, 32'hff);
    rdc("status write ignored", ADDR_IRQ_STAT, 32'h0, 1'b0);
    $display("test interrupt mask done");
    // Fault still present across the clear
    @(posedge pclk);
    det[3] <= 1'b1;
    det[4] <= 1'b1;
    wr(ADDR_INTEG, 32'h1 << MEM_BIT);
    rdc("flag re-set", ADDR_INTEG, 32'h0000e400, 1'b0);
    wr(ADDR_OCC, 32'h1 << A_HIGH_BIT);
    rdc("occ flag re-set", ADDR_OCC, 32'h00000007, 1'b0);
    rst(1'b1);
    rdc("after reset", ADDR_INTEG, 32'h0000ec00, 1'b0);
    $display("test persistent fault done");
    // Backup bank loaded: bit 10 low, summary untouched, bit read-only
    rst(1'b0);
    rdc("backup bank", ADDR_INTEG, 32'h0000e800, 1'b0);
    chk("summary bank", 32'h1, {31'h0, summary});
    wr(ADDR_INTEG, 32'h0000ffff);
    rdc("bank read only", ADDR_INTEG, 32'h0000e800, 1'b0);
    rst(1'b1);
    rdc("primary bank", ADDR_INTEG, 32'h0000ec00, 1'b0);
    $display("test fuse bank done");
    stop_test();
  end
endmodule : test_fsf_status_regs

`default_nettype wire
